// [hdl/mie_map.vh]
// Opcode fields, reset values and sizes for the instruction executor
// Notes on behaviour
// - AND literal into accumulator, update zero
// - AND register, zero flag, d picks destination
// - Bit clear/set on 00h-3Fh, no flags
// - Skip-if-clear: bit 0 discards next, two cycles
// - Skip-if-set: bit 1 discards next, two cycles
// - Call pushes PC+1, loads 12-bit target
// - Clear register or accumulator, zero flag set
// - Watchdog kick clears timer, updates status bits
// - Complement register, zero flag, d destination
// - Decrement register, zero flag, d destination
// - Decrement-skip, no flags, zero skips next
// - Jump loads 12-bit target, two cycles
// - Increment register, zero flag, d destination
// - Increment-skip, no flags, zero skips next
// - OR literal into accumulator, update zero
// - OR register, zero flag, d destination
// - Load accumulator from register, no flags
// - Load literal into accumulator, no flags
// - Store accumulator to register, no flags
// - Second plane load/store via 8-bit address
// - Subroutine return pops stack into PC
// - Interrupt return pops PC, sets irq allow
// - Add sets carry, half carry, zero
`ifndef MIE_MAP_VH
`define MIE_MAP_VH
`define MIE_PC_W 12
`define MIE_STK_DEPTH 3'h6
`define MIE_SP_W 3
`define MIE_PC_RST 12'h000
`define MIE_ACC_RST 8'h00
`define MIE_OP_NOP 14'h0000
`define MIE_OP_RET 14'h0040
`define MIE_OP_INTERRUPT_EXIT 14'h0060
`define MIE_OP_CLRACC 14'h0140
`define MIE_OP_KICK 14'h1e04
`define MIE_GRP_BYTE 2'h0
`define MIE_GRP_BIT 2'h1
`define MIE_GRP_CALL 2'h2
`define MIE_GRP_JUMP 2'h3
`define MIE_B_STORE 4'h0
`define MIE_B_CLR 4'h1
`define MIE_B_DEC 4'h3
`define MIE_B_OR 4'h4
`define MIE_B_AND 4'h5
`define MIE_B_ADD 4'h7
`define MIE_B_MOVF 4'h8
`define MIE_B_COM 4'h9
`define MIE_B_INC 4'ha
`define MIE_B_DECSZ 4'hb
`define MIE_B_INCSZ 4'hf
`define MIE_L_MOVL 4'h9
`define MIE_L_ORL 4'ha
`define MIE_L_ANDL 4'hb
`define MIE_L_WRPL 4'he
`define MIE_L_RDPL 4'hf
`define MIE_BIT_CLR 2'h0
`define MIE_BIT_SET 2'h1
`define MIE_BIT_TSTC 2'h2
`define MIE_BIT_TSTS 2'h3
`endif

// [hdl/mie_executor.v]
// Instruction decode and execute core with hardware return stack
`include "mie_map.vh"
`default_nettype none
module mie_executor (
   input wire clock,
   input wire rst,
   input wire ce,
   input wire [13:0] instr,
   output reg [`MIE_PC_W-1:0] pc_r,
   output reg [7:0] reg_addr_r,
   input wire [7:0] reg_rdata,
   output reg plane_sel_r,
   output reg reg_we,
   output reg [7:0] reg_wdata,
   output reg [7:0] acc_r,
   output reg zero_flag_r,
   output reg carry_flag_r,
   output reg half_carry_flag_r,
   output reg global_irq_allow_r,
   output reg kick_watchdog_op,
   output reg watchdog_expiry_bit_r,
   output reg powerdown_bit_r
);
   // Three-state sequencer: fetch drives the operand address, exec acts, flush idles after jumps and skips
   localparam ST_FETCH = 3'b001;
   localparam ST_EXEC = 3'b010;
   localparam ST_FLUSH = 3'b100;
   reg [2:0] state_r;
   reg [13:0] ir_r;
   reg [`MIE_PC_W-1:0] stack_r [0:`MIE_STK_DEPTH-1];
   reg [`MIE_SP_W-1:0] sp_r;
   wire [1:0] grp = ir_r[13:12];
   wire [3:0] sub = ir_r[11:8];
   wire dbit = ir_r[7];
   wire [2:0] bsel = ir_r[8:6];
   wire [7:0] lit = ir_r[7:0];
   wire [`MIE_SP_W-1:0] sp_top = sp_r - 3'h1;
   // An empty stack returns slot 0 rather than reading past the array
   wire [`MIE_SP_W-1:0] pop_slot = (sp_r == 3'h0) ? 3'h0 : sp_top;
   // A full stack keeps overwriting its newest slot instead of wrapping
   wire [`MIE_SP_W-1:0] push_slot = (sp_r == `MIE_STK_DEPTH) ? sp_top : sp_r;
   wire [`MIE_PC_W-1:0] pc_inc = pc_r + 12'h001;
   wire [8:0] add_sum = {1'b0, acc_r} + {1'b0, reg_rdata};
   wire [4:0] add_low = {1'b0, acc_r[3:0]} + {1'b0, reg_rdata[3:0]};
   reg [7:0] res;
   reg to_acc, to_reg, upd_z, skip, jump;
   reg [`MIE_PC_W-1:0] jump_pc;
   reg push, pop, is_add, set_irq, kick;
   reg [7:0] bit_mask;
   always @*
   begin
      res = 8'h00;
      to_acc = 1'b0;
      to_reg = 1'b0;
      upd_z = 1'b0;
      skip = 1'b0;
      jump = 1'b0;
      jump_pc = ir_r[11:0];
      push = 1'b0;
      pop = 1'b0;
      is_add = 1'b0;
      set_irq = 1'b0;
      kick = 1'b0;
      bit_mask = 8'h01 << bsel;
      case (grp)
         `MIE_GRP_BYTE:
         begin
            // Both returns pop; only the interrupt form has bit 5 set
            if (ir_r == `MIE_OP_RET || ir_r == `MIE_OP_INTERRUPT_EXIT)
            begin
               jump = 1'b1;
               pop = 1'b1;
               jump_pc = stack_r[pop_slot];
               set_irq = ir_r[5];
            end
            else
            begin
               case (sub)
                  `MIE_B_STORE:
                  begin
                     res = acc_r;
                     to_reg = dbit;
                  end
                  `MIE_B_CLR:
                  begin
                     res = 8'h00;
                     to_reg = dbit;
                     to_acc = (ir_r == `MIE_OP_CLRACC);
                     upd_z = to_reg | to_acc;
                  end
                  `MIE_B_DEC, `MIE_B_DECSZ:
                  begin
                     res = reg_rdata - 8'h01;
                     upd_z = (sub == `MIE_B_DEC);
                     skip = (sub == `MIE_B_DECSZ) && res == 8'h00;
                     to_acc = ~dbit;
                     to_reg = dbit;
                  end
                  `MIE_B_INC, `MIE_B_INCSZ:
                  begin
                     res = reg_rdata + 8'h01;
                     upd_z = (sub == `MIE_B_INC);
                     skip = (sub == `MIE_B_INCSZ) && res == 8'h00;
                     to_acc = ~dbit;
                     to_reg = dbit;
                  end
                  `MIE_B_OR, `MIE_B_AND, `MIE_B_COM, `MIE_B_ADD:
                  begin
                     if (sub == `MIE_B_OR)
                        res = acc_r | reg_rdata;
                     else if (sub == `MIE_B_AND)
                        res = acc_r & reg_rdata;
                     else if (sub == `MIE_B_COM)
                        res = ~reg_rdata;
                     else
                        res = add_sum[7:0];
                     is_add = (sub == `MIE_B_ADD);
                     upd_z = 1'b1;
                     to_acc = ~dbit;
                     to_reg = dbit;
                  end
                  `MIE_B_MOVF:
                  begin
                     res = reg_rdata;
                     to_acc = ~dbit;
                  end
                  default:
                  begin
                     res = 8'h00;
                  end
               endcase
            end
         end
         `MIE_GRP_BIT:
         begin
            // Bit ops keep their kind in bits 10:9, the bit number in 8:6
            if (!ir_r[11])
            begin
               case (ir_r[10:9])
                  `MIE_BIT_CLR:
                  begin
                     res = reg_rdata & ~bit_mask;
                     to_reg = 1'b1;
                  end
                  `MIE_BIT_SET:
                  begin
                     res = reg_rdata | bit_mask;
                     to_reg = 1'b1;
                  end
                  `MIE_BIT_TSTC:
                     skip = (reg_rdata & bit_mask) == 8'h00;
                  default:
                     skip = (reg_rdata & bit_mask) != 8'h00;
               endcase
            end
            // Kick shares its prefix with the plane store, so it goes first
            else if (ir_r == `MIE_OP_KICK)
               kick = 1'b1;
            else
            begin
               case (sub)
                  `MIE_L_ANDL:
                  begin
                     res = acc_r & lit;
                     to_acc = 1'b1;
                     upd_z = 1'b1;
                  end
                  `MIE_L_ORL:
                  begin
                     res = acc_r | lit;
                     to_acc = 1'b1;
                     upd_z = 1'b1;
                  end
                  `MIE_L_MOVL:
                  begin
                     res = lit;
                     to_acc = 1'b1;
                  end
                  `MIE_L_RDPL:
                  begin
                     res = reg_rdata;
                     to_acc = 1'b1;
                  end
                  `MIE_L_WRPL:
                  begin
                     res = acc_r;
                     to_reg = 1'b1;
                  end
                  default:
                     res = 8'h00;
               endcase
            end
         end
         `MIE_GRP_CALL:
         begin
            jump = 1'b1;
            push = 1'b1;
         end
         default:
            jump = 1'b1;
      endcase
   end
   // Write strobe only in the execute phase; data comes from the datapath
   always @*
   begin
      reg_we = ce && state_r == ST_EXEC && to_reg;
      reg_wdata = res;
   end
   integer i;
   always @(posedge clock)
   begin
      if (rst)
      begin
         state_r <= ST_FETCH;
         ir_r <= `MIE_OP_NOP;
         pc_r <= `MIE_PC_RST;
         reg_addr_r <= 8'h00;
         plane_sel_r <= 1'b0;
         acc_r <= `MIE_ACC_RST;
         zero_flag_r <= 1'b0;
         carry_flag_r <= 1'b0;
         half_carry_flag_r <= 1'b0;
         global_irq_allow_r <= 1'b0;
         kick_watchdog_op <= 1'b0;
         watchdog_expiry_bit_r <= 1'b1;
         powerdown_bit_r <= 1'b1;
         sp_r <= 3'h0;
         for (i = 0; i < `MIE_STK_DEPTH; i = i + 1)
            stack_r[i] <= 12'h000;
      end
      else if (ce)
      begin
         kick_watchdog_op <= 1'b0;
         case (state_r)
            ST_FETCH:
            begin
               ir_r <= instr;
               // Bit-op addresses are six bits wide, so 00h-3Fh only
               if (instr[13:12] == `MIE_GRP_BIT && instr[11:10] == 2'b11)
               begin
                  reg_addr_r <= instr[7:0];
                  plane_sel_r <= 1'b1;
               end
               else if (instr[13:12] == `MIE_GRP_BIT)
               begin
                  reg_addr_r <= {2'b00, instr[5:0]};
                  plane_sel_r <= 1'b0;
               end
               else
               begin
                  reg_addr_r <= {1'b0, instr[6:0]};
                  plane_sel_r <= 1'b0;
               end
               state_r <= ST_EXEC;
            end
            ST_EXEC:
            begin
               if (to_acc)
                  acc_r <= res;
               if (upd_z)
                  zero_flag_r <= (res == 8'h00);
               if (is_add)
               begin
                  carry_flag_r <= add_sum[8];
                  half_carry_flag_r <= add_low[4];
               end
               if (set_irq)
                  global_irq_allow_r <= 1'b1;
               if (kick)
               begin
                  kick_watchdog_op <= 1'b1;
                  watchdog_expiry_bit_r <= 1'b1;
                  powerdown_bit_r <= 1'b1;
               end
               if (push)
               begin
                  stack_r[push_slot] <= pc_inc;
                  // Overflow keeps the top slot overwritten, no wrap
                  if (sp_r != `MIE_STK_DEPTH)
                     sp_r <= sp_r + 3'h1;
               end
               if (pop && sp_r != 3'h0)
                  sp_r <= sp_top;
               if (jump)
                  pc_r <= jump_pc;
               else if (skip)
                  pc_r <= pc_r + 12'h002;
               else
                  pc_r <= pc_inc;
               // Two-cycle ops spend an idle slot in place of the next word
               state_r <= (jump | skip) ? ST_FLUSH : ST_FETCH;
            end
            ST_FLUSH:
               state_r <= ST_FETCH;
            default:
               state_r <= ST_FETCH;
         endcase
      end
   end
endmodule // mie_executor
`default_nettype wire

// [testbench/mie_checker.sv]
// Port assertions for the instruction executor
`default_nettype none
module mie_checker (
   input wire logic clock,
   input wire logic rst,
   input wire logic [13:0] instr,
   input wire logic [11:0] pc_r,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_we,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] acc_r,
   input wire logic global_irq_allow_r,
   input wire logic kick_watchdog_op,
   input wire logic watchdog_expiry_bit_r,
   input wire logic powerdown_bit_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // The strobe stands in EXEC, while instr still shows the current word
   a_store_data: assert property (
      reg_we && instr[13:7] == 7'h01 |-> reg_wdata == acc_r)
      else $error("store data wrong");
   a_inc_data: assert property (
      reg_we && instr[13:8] == 6'h0a |-> reg_wdata == reg_rdata + 8'h01)
      else $error("increment data wrong");
   a_bitclr_data: assert property (
      reg_we && instr[13:9] == 5'h08 |->
      reg_wdata == (reg_rdata & ~(8'h01 << instr[8:6])))
      else $error("bit clear data wrong");
   a_branch_target: assert property (
      $changed(pc_r) && $past(instr[13]) |-> pc_r == $past(instr[11:0]))
      else $error("branch target wrong");
   a_literal_step: assert property (
      $changed(pc_r) && $past(instr[13:8]) == 6'h19 |->
      pc_r == $past(pc_r) + 12'h001 && acc_r == $past(instr[7:0]))
      else $error("literal load wrong");
   a_dec_skip: assert property (
      $changed(pc_r) && $past(instr[13:8]) == 6'h0b |-> pc_r == $past(pc_r)
      + (($past(reg_rdata) == 8'h01) ? 12'h002 : 12'h001))
      else $error("decrement skip wrong");
   a_interrupt_exit_allow: assert property (
      $changed(pc_r) && $past(instr) == 14'h0060 |-> global_irq_allow_r)
      else $error("irq allow not set");
   a_kick_status: assert property (
      kick_watchdog_op |-> watchdog_expiry_bit_r && powerdown_bit_r)
      else $error("status bits not set");
   a_kick_source: assert property (
      $rose(kick_watchdog_op) |-> $past(instr) == 14'h1e04)
      else $error("kick pulse without kick word");
endmodule // mie_checker
`default_nettype wire

// [testbench/mie_mem_model.sv]
// Program memory and two-plane register file beside the executor
`default_nettype none
module mie_mem_model (
   input wire logic clock,
   input wire logic [11:0] pc_r,
   output logic [13:0] instr,
   input wire logic [7:0] reg_addr_r,
   input wire logic plane_sel_r,
   input wire logic reg_we,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] rom [0:4095];
   logic [7:0] rf [0:511];
   // Empty words jump to themselves, so a runaway core parks in place
   initial
   begin
      for (int i = 0; i < 4096; i++)
         rom[i] = {2'h3, i[11:0]};
      for (int i = 0; i < 512; i++)
         rf[i] = 8'h00;
   end
   assign instr = rom[pc_r];
   assign reg_rdata = rf[{plane_sel_r, reg_addr_r}];
   always @(posedge clock)
      if (reg_we)
         rf[{plane_sel_r, reg_addr_r}] <= reg_wdata;
endmodule // mie_mem_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the instruction executor
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   wire [13:0] instr;
   wire [11:0] pc_r;
   wire [7:0] reg_addr_r, reg_rdata, reg_wdata, acc_r;
   wire plane_sel_r, reg_we, zero_flag_r, carry_flag_r, half_carry_flag_r;
   wire global_irq_allow_r, kick_watchdog_op, watchdog_expiry_bit_r;
   wire powerdown_bit_r;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int seed = 32'h73b968fb;
   logic [7:0] k1, k2, k3, r0, r1, r2, x, m;
   logic [2:0] b;
   mie_executor dut_u (.clock(clock), .rst(rst), .ce(ce), .instr(instr),
      .pc_r(pc_r), .reg_addr_r(reg_addr_r), .reg_rdata(reg_rdata),
      .plane_sel_r(plane_sel_r), .reg_we(reg_we), .reg_wdata(reg_wdata),
      .acc_r(acc_r), .zero_flag_r(zero_flag_r), .carry_flag_r(carry_flag_r),
      .half_carry_flag_r(half_carry_flag_r),
      .global_irq_allow_r(global_irq_allow_r),
      .kick_watchdog_op(kick_watchdog_op),
      .watchdog_expiry_bit_r(watchdog_expiry_bit_r),
      .powerdown_bit_r(powerdown_bit_r));
   mie_mem_model mem_u (.clock(clock), .pc_r(pc_r), .instr(instr),
      .reg_addr_r(reg_addr_r), .plane_sel_r(plane_sel_r), .reg_we(reg_we),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   initial
   begin
      forever #2 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         n_errors = n_errors + 1;
         finish_test();
      end
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Reset, then run with random stalls until the park address shows
   task run(input logic [11:0] stop);
      int n;
      ce = 1'b1;
      rst = 1'b1;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      n = 0;
      while (pc_r !== stop && n < 400)
      begin
         @(negedge clock);
         ce = ($random(seed) & 3) != 0;
         n = n + 1;
      end
      ce = 1'b1;
      repeat (6) @(negedge clock);
      check(pc_r[7:0], stop[7:0]);
      $display("program parked at %h done", stop);
   endtask
   initial
   begin
      @(negedge clock);
      for (int i = 0; i < 4; i++)
      begin
         {k1, k2, k3, r0} = $random(seed);
         {r1, r2, x} = 24'($random(seed));
         b = x[2:0];
         k3[7] = 1'b1;
         // First pass forces a zero count so the skip is taken
         if (i == 0)
            r0 = 8'h00;
         mem_u.rf[9'h010] = r0;
         mem_u.rf[9'h012] = r2;
         mem_u.rf[9'h013] = x;
         mem_u.rf[9'h140] = r1;
         mem_u.rom[0] = {6'h19, k1};
         mem_u.rom[1] = 14'h0590;
         mem_u.rom[2] = {6'h1a, k2};
         mem_u.rom[3] = 14'h0a90;
         mem_u.rom[4] = 14'h0091;
         mem_u.rom[5] = {6'h1e, k3};
         mem_u.rom[6] = 14'h1f40;
         mem_u.rom[7] = 14'h2020;
         mem_u.rom[8] = 14'h3008;
         mem_u.rom[32] = 14'h0b90;
         mem_u.rom[33] = {5'h09, b, 6'h12};
         mem_u.rom[34] = 14'h0193;
         mem_u.rom[35] = 14'h0040;
         run(12'h008);
         m = 8'h01 << b;
         check(acc_r, r1);
         check(mem_u.rf[9'h010], k1 & r0);
         check(mem_u.rf[9'h011], k1 | k2);
         check(mem_u.rf[{1'b1, k3}], k1 | k2);
         check(mem_u.rf[9'h012], (k1 & r0) == 0 ? r2 : r2 | m);
         check(mem_u.rf[9'h013], 8'h00);
         check(zero_flag_r, 1'b1);
         {k1, k2, r0, x} = $random(seed);
         b = x[2:0];
         m = 8'h01 << b;
         mem_u.rf[9'h014] = r0;
         mem_u.rom[0] = 14'h1e04;
         mem_u.rom[1] = 14'h2010;
         mem_u.rom[2] = 14'h3002;
         mem_u.rom[16] = {5'h08, b, 6'h14};
         // Tested bit is now low: one form skips, the other does not
         mem_u.rom[17] = {(i[0] ? 5'h0a : 5'h0b), b, 6'h14};
         mem_u.rom[18] = 14'h0994;
         mem_u.rom[19] = {6'h19, k1};
         mem_u.rom[20] = {6'h1b, k2};
         mem_u.rom[21] = 14'h0060;
         run(12'h002);
         x = r0 & ~m;
         check(mem_u.rf[9'h014], i[0] ? x : ~x);
         check(acc_r, k1 & k2);
         check(zero_flag_r, (k1 & k2) == 8'h00);
         check(global_irq_allow_r, 1'b1);
         check(watchdog_expiry_bit_r & powerdown_bit_r, 1'b1);
         {k1, r0, r1, r2} = $random(seed);
         k2 = 8'($random(seed));
         // First pass wraps the counter so the increment skip is taken
         if (i == 0)
            r2 = 8'hff;
         mem_u.rf[9'h015] = r0;
         mem_u.rf[9'h016] = r1;
         mem_u.rf[9'h017] = r2;
         mem_u.rf[9'h019] = k2;
         mem_u.rom[0] = {6'h19, k1};
         mem_u.rom[1] = 14'h0795;
         mem_u.rom[2] = 14'h0416;
         mem_u.rom[3] = 14'h0098;
         mem_u.rom[4] = 14'h0396;
         mem_u.rom[5] = 14'h0f97;
         mem_u.rom[6] = 14'h0099;
         mem_u.rom[7] = 14'h0816;
         mem_u.rom[8] = 14'h009a;
         mem_u.rom[9] = 14'h0140;
         mem_u.rom[10] = 14'h300a;
         run(12'h00a);
         x = k1 | r1;
         check(mem_u.rf[9'h015], 8'(k1 + r0));
         check(carry_flag_r, (k1 + r0) > 9'h0ff);
         check(half_carry_flag_r, (k1[3:0] + r0[3:0]) > 5'h0f);
         check(mem_u.rf[9'h018], x);
         check(mem_u.rf[9'h016], r1 - 8'h01);
         check(mem_u.rf[9'h017], r2 + 8'h01);
         check(mem_u.rf[9'h019], r2 == 8'hff ? k2 : x);
         check(mem_u.rf[9'h01a], r1 - 8'h01);
         check(acc_r, 8'h00);
         check(zero_flag_r, 1'b1);
      end
      finish_test();
   end
endmodule // tb_top
bind mie_executor mie_checker chk_u (.clock(clock), .rst(rst),
   .instr(instr), .pc_r(pc_r), .reg_rdata(reg_rdata), .reg_we(reg_we),
   .reg_wdata(reg_wdata), .acc_r(acc_r),
   .global_irq_allow_r(global_irq_allow_r),
   .kick_watchdog_op(kick_watchdog_op),
   .watchdog_expiry_bit_r(watchdog_expiry_bit_r),
   .powerdown_bit_r(powerdown_bit_r));
`default_nettype wire
